//--- sim/ctsf_checker.sv
// bound checker for the touch scan controller ports
`default_nettype none
module ctsf_checker #(
    parameter NPAD = 10,
    parameter CW = 16
) (
    input wire logic clk_sys, // clock
    input wire logic srst, // sync reset
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic wb_we_i, // write
    input wire logic wb_stb_i, // strobe
    input wire logic wb_cyc_i, // cycle
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic [NPAD-1:0] pad_pulse_input, // pad pulses
    input wire logic touch_bias_powerup, // bias enable
    input wire logic [NPAD-1:0] pad_powerup, // pad power-up
    input wire logic [NPAD-1:0] pad_start, // pad start
    input wire logic initial_level_select, // swing start level
    input wire logic irq // interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("request not answered in one cycle");
    property p_start_gate;
        |pad_start |-> pad_powerup == pad_start && touch_bias_powerup;
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("pad start without matching power-up");
    property p_pwr_bias;
        |pad_powerup |-> touch_bias_powerup;
    endproperty
    a_pwr_bias: assert property (p_pwr_bias)
        else $error("pad power-up without bias");
    property p_bias_first;
        $rose(touch_bias_powerup) |-> (pad_start == '0)[*2];
    endproperty
    a_bias_first: assert property (p_bias_first)
        else $error("pad start too soon after bias");
    property p_start_after;
        $rose(|pad_start) |-> $past(|pad_powerup);
    endproperty
    a_start_after: assert property (p_start_after)
        else $error("pad start before power-up");
    property p_drop;
        $fell(touch_bias_powerup) |-> pad_powerup == '0 && pad_start == '0;
    endproperty
    a_drop: assert property (p_drop)
        else $error("pad controls outlive bias");
    property p_gap;
        $fell(touch_bias_powerup) |=> !touch_bias_powerup;
    endproperty
    a_gap: assert property (p_gap)
        else $error("scans run back to back");
    property p_irq_late;
        // a mask write may raise irq at any time, so leave it out
        $rose(irq) && !(wb_ack_o && wb_we_i) |->
            !touch_bias_powerup && $past(!touch_bias_powerup);
    endproperty
    a_irq_late: assert property (p_irq_late)
        else $error("interrupt before scan completed");

    c_irq: cover property ($rose(irq));
    c_window: cover property ($rose(|pad_start));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind ctsf_top ctsf_checker #(.NPAD(NPAD), .CW(CW)) u_ctsf_checker (
    .clk_sys(clk_sys), .srst(srst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pad_pulse_input(pad_pulse_input),
    .touch_bias_powerup(touch_bias_powerup), .pad_powerup(pad_powerup),
    .pad_start(pad_start), .initial_level_select(initial_level_select),
    .irq(irq));
`default_nettype wire

//--- sim/ctsf_pad_model.sv
// front-end model: pads toggle every cycle while not started, swing slower when touched
`default_nettype none
module ctsf_pad_model #(
    parameter int NPAD = 10
) (
    input wire logic clk_sys, // model clock
    input wire logic [NPAD-1:0] pad_start, // per-pad start from the block
    input wire logic [NPAD-1:0] touched, // bench: finger on the pad
    output logic [NPAD-1:0] pad_pulse_input = '0 // comparator pulses
);
    logic [3:0] phase [NPAD] = '{default: 4'h0};

    // period 4 cycles untouched, 16 touched; an idle pad toggles every
    // cycle so that counting outside the window shows up as a wrong count
    always @(posedge clk_sys) begin
        for (int i = 0; i < NPAD; i++) begin
            phase[i] <= pad_start[i] ? phase[i] + 4'h1 : 4'h0;
            if (!pad_start[i]) begin
                pad_pulse_input[i] <= ~pad_pulse_input[i];
            end else begin
                pad_pulse_input[i] <= touched[i] ? phase[i][3] : phase[i][1];
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the touch scan controller
`include "ctsf_map.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, touch_bias_powerup, initial_level_select, irq;
    wire [9:0] pad_pulse_input, pad_powerup, pad_start;
    logic [9:0] touched = 10'h000;
    logic [31:0] rd;
    int miscompares = 0, checks_done = 0, cycles = 0;

    ctsf_top u_ctsf_top (.clk_sys(clk_sys), .srst(srst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pad_pulse_input(pad_pulse_input),
        .touch_bias_powerup(touch_bias_powerup), .pad_powerup(pad_powerup),
        .pad_start(pad_start), .initial_level_select(initial_level_select),
        .irq(irq));
    ctsf_pad_model u_ctsf_pad_model (.clk_sys(clk_sys),
        .pad_start(pad_start), .touched(touched),
        .pad_pulse_input(pad_pulse_input));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard: a full run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then release
    task automatic wb_cycle(input logic w, input logic [7:0] a,
                            input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
    endtask

    task automatic rc(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // polls for completion; the count bounds the wait
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            wb_cycle(1'b0, `CTSF_ADR_INTSTAT, 32'h0);
            n++;
        end while (rd[`CTSF_INT_DONE] !== 1'b1 && n < 200);
        check("scan done", rd[`CTSF_INT_DONE], 1'b1);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        // reset values, and an unmapped place that must stay empty
        rc("interval", `CTSF_ADR_INTERVAL, 32'h0100);
        rc("timing", `CTSF_ADR_TIMING, 32'h0200_0404);
        rc("threshold", 8'ha4, 32'h0040);
        wr(8'hfc, 32'hffff_ffff);
        rc("unmapped", 8'hfc, 32'h0);
        // short timing, pad 8 disabled, pad 0 alone in the first group
        wr(`CTSF_ADR_TIMING, 32'h003f_0202);
        wr(`CTSF_ADR_PADEN, 32'h2ff);
        wr(`CTSF_ADR_GRP1, 32'h001);
        wr(`CTSF_ADR_GRP2, 32'h002);
        wr(`CTSF_ADR_INTMASK, 32'h3);
        for (int i = 0; i < 10; i++) begin
            wr(8'h80 + 8'(4 * i), 32'd10);
        end
        rc("threshold set", 8'h84, 32'd10);
        touched <= 10'h001;
        // a trigger only counts once software mode is already selected
        wr(`CTSF_ADR_CTRL, 32'h1);
        wr(`CTSF_ADR_CTRL, 32'h9);
        while (pad_start === 10'h000) @(posedge clk_sys);
        check("pad start", pad_start, 32'h2ff);
        check("pad power", pad_powerup, 32'h2ff);
        check("bias", touch_bias_powerup, 1'b1);
        wait_done();
        rc("touched", `CTSF_ADR_STATUS, 32'h001);
        rc("int status", `CTSF_ADR_INTSTAT, 32'h3);
        check("irq set", irq, 1'b1);
        wb_cycle(1'b0, 8'h40, 32'h0);
        check("pad 0 count low", rd < 32'd9, 1'b1);
        wb_cycle(1'b0, 8'h44, 32'h0);
        check("pad 1 count high", rd > 32'd11, 1'b1);
        rc("pad 8 count", 8'h60, 32'h0);
        wr(`CTSF_ADR_INTSTAT, 32'h3);
        rc("int cleared", `CTSF_ADR_INTSTAT, 32'h0);
        check("irq cleared", irq, 1'b0);
        // a trigger must give one scan, never a second
        repeat (200) @(posedge clk_sys);
        rc("single scan", `CTSF_ADR_INTSTAT, 32'h0);
        // both groups required: pad 1 untouched, done masked so only wakeup can raise irq
        wr(`CTSF_ADR_INTMASK, 32'h2);
        wr(`CTSF_ADR_CTRL, 32'hd);
        wait_done();
        rc("one group only", `CTSF_ADR_INTSTAT, 32'h1);
        check("irq masked", irq, 1'b0);
        wr(`CTSF_ADR_INTSTAT, 32'h3);
        wr(`CTSF_ADR_INTMASK, 32'h3);
        touched <= 10'h003;
        wr(`CTSF_ADR_CTRL, 32'hd);
        wait_done();
        rc("both groups", `CTSF_ADR_INTSTAT, 32'h3);
        rc("touched two", `CTSF_ADR_STATUS, 32'h003);
        wr(`CTSF_ADR_INTSTAT, 32'h3);
        // timer mode with raised start level: scans repeat unprompted
        wr(`CTSF_ADR_INTMASK, 32'h1);
        wr(`CTSF_ADR_INTERVAL, 32'h20);
        wr(`CTSF_ADR_CTRL, 32'h2);
        check("start level", initial_level_select, 1'b1);
        wait_done();
        wr(`CTSF_ADR_INTSTAT, 32'h3);
        wait_done();
        wr(`CTSF_ADR_CTRL, 32'h1);
        end_sim();
    end
endmodule
`default_nettype wire

//--- src/ctsf_map.vh
// register map, field positions and reset values of the touch scan block
`ifndef CTSF_MAP_VH
`define CTSF_MAP_VH
`define CTSF_ADR_CTRL 8'h00
`define CTSF_ADR_INTERVAL 8'h04
`define CTSF_ADR_TIMING 8'h08
`define CTSF_ADR_PADEN 8'h0c
`define CTSF_ADR_GRP1 8'h10
`define CTSF_ADR_GRP2 8'h14
`define CTSF_ADR_STATUS 8'h18
`define CTSF_ADR_INTSTAT 8'h1c
`define CTSF_ADR_INTMASK 8'h20
`define CTSF_ADR_COUNT_HI 2'b01
`define CTSF_ADR_THRESH_HI 2'b10
`define CTSF_CTRL_SRC 0
`define CTSF_CTRL_LEVEL 1
`define CTSF_CTRL_BOTH 2
`define CTSF_CTRL_TRIG 3
`define CTSF_INT_DONE 0
`define CTSF_INT_WAKE 1
`define CTSF_STATUS_BUSY 16
`define CTSF_RST_INTERVAL 16'h0100
`define CTSF_RST_DLY_BIAS 8'h04
`define CTSF_RST_DLY_PWR 8'h04
`define CTSF_RST_WINDOW 16'h0200
`define CTSF_RST_THRESH 16'h0040
`endif

//--- src/ctsf_pad_counter.v
// saturating rising-edge pulse counter for one touch pad
`default_nettype none
module ctsf_pad_counter #(
    parameter CW = 16
) (
    input wire clk_sys, // system clock
    input wire srst, // synchronous reset, active high
    input wire clr, // clear count, one-cycle pulse
    input wire en, // count window open for this pad
    input wire pulse, // synchronised pad pulse level
    output reg [CW-1:0] count // pulses seen in the window
);
    reg prev;

    // clear wins over counting; saturate so a long window cannot wrap
    always @(posedge clk_sys) begin
        if (srst) begin
            prev <= 1'b0;
            count <= {CW{1'b0}};
        end else begin
            prev <= pulse;
            if (clr)
                count <= {CW{1'b0}};
            else if (en && pulse && !prev && !(&count))
                count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

//--- src/ctsf_sync.v
// two-stage synchroniser for asynchronous pad pulse inputs
`default_nettype none
module ctsf_sync #(
    parameter W = 10
) (
    input wire clk_sys, // system clock
    input wire srst, // synchronous reset, active high
    input wire [W-1:0] async_in, // asynchronous levels
    output reg [W-1:0] sync_out // synchronised levels
);
    reg [W-1:0] meta;

    // first stage is read only by the second stage
    always @(posedge clk_sys) begin
        if (srst) begin
            meta <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

//--- src/ctsf_top.v
// touch pad scan controller with wishbone register slave
//
// Functional notes
// - with source select 1, each software trigger starts exactly one scan.
// - with source select 0, an interval timer starts scans, trigger ignored.
// - the controller runs standalone in sleep; the interval sets the period.
// - controller and counters run on the fast clock, nominally 8 MHz.
// - each scan drives bias, then pad power-up, then pad start, with delays.
// - pad power-up and pad start are gated per pad by the pad-enable mask.
// - pulses of all ten pads are counted at once; each count is readable.
// - a pad is touched when its count is below its threshold.
// - two 10-bit masks place pads into the first and second wakeup groups.
// - by default wakeup fires when any first-group pad is touched.
// - an option requires touched pads in both groups for wakeup.
// - an output selects the initial level of the charge/discharge cycle.
//
// Our own choices: the Wishbone register port and the address map.
`include "ctsf_map.vh"
`default_nettype none
module ctsf_top #(
    parameter NPAD = 10,
    parameter CW = 16
) (
    input wire clk_sys, // fast clock, nominal 8 MHz
    input wire srst, // synchronous reset, active high
    input wire [7:0] wb_adr_i, // wishbone byte address
    input wire [31:0] wb_dat_i, // wishbone write data
    input wire [3:0] wb_sel_i, // wishbone byte enables
    input wire wb_we_i, // wishbone write
    input wire wb_stb_i, // wishbone strobe
    input wire wb_cyc_i, // wishbone cycle
    output reg [31:0] wb_dat_o, // wishbone read data
    output reg wb_ack_o, // wishbone acknowledge
    input wire [NPAD-1:0] pad_pulse_input, // pad pulses, asynchronous
    output reg touch_bias_powerup, // front-end bias enable
    output reg [NPAD-1:0] pad_powerup, // per-pad power-up
    output reg [NPAD-1:0] pad_start, // per-pad start
    output reg initial_level_select, // starting level of swing
    output reg irq // level interrupt
);
    localparam S_IDLE = 3'd0;
    localparam S_BIAS = 3'd1;
    localparam S_PWR = 3'd2;
    localparam S_MEAS = 3'd3;
    localparam S_DONE = 3'd4;

    reg start_source_select;
    reg both_groups;
    reg sw_pending;
    reg [15:0] measurement_interval_cycles;
    reg [7:0] dly_bias;
    reg [7:0] dly_pwr;
    reg [15:0] window;
    reg [NPAD-1:0] pad_enable_mask;
    reg [NPAD-1:0] first_group_mask;
    reg [NPAD-1:0] second_group_mask;
    reg [NPAD-1:0] touched;
    reg [1:0] int_stat;
    reg [1:0] int_mask;
    reg [CW-1:0] thresh [0:NPAD-1];
    reg [2:0] state;
    reg [15:0] st_cnt;
    reg [15:0] tmr;
    reg cnt_clr;
    reg cnt_en;
    reg [31:0] rd_data;
    wire [NPAD-1:0] next_touched;
    reg next_wake;

    wire [NPAD-1:0] pulse_s;
    wire [NPAD*CW-1:0] cnt_flat;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i;
    wire [3:0] idx = wb_adr_i[5:2];
    wire idx_ok = idx < NPAD;
    wire busy = state != S_IDLE;
    wire [31:0] ctrl_cur = {28'h0000000, 1'b0, both_groups,
                            initial_level_select, start_source_select};
    wire trig_wr = wr && wb_adr_i == `CTSF_ADR_CTRL && wb_sel_i[0] &&
                   wb_dat_i[`CTSF_CTRL_TRIG];
    // only the active source may launch a scan
    wire start_req = start_source_select ? sw_pending :
                     (tmr >= measurement_interval_cycles);

    // apply byte enables to a word write
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (sel[k])
                    merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    // pad pulses come from the analog domain, so synchronise first
    ctsf_sync #(
        .W(NPAD)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in(pad_pulse_input),
        .sync_out(pulse_s)
    );

    // one counter per pad, all counting in parallel
    genvar g;
    generate
        for (g = 0; g < NPAD; g = g + 1) begin : g_pad
            ctsf_pad_counter #(
                .CW(CW)
            ) u_cnt (
                .clk_sys(clk_sys),
                .srst(srst),
                .clr(cnt_clr),
                .en(cnt_en && pad_enable_mask[g]),
                .pulse(pulse_s[g]),
                .count(cnt_flat[g*CW +: CW])
            );
            // disabled pads never report a touch
            assign next_touched[g] = pad_enable_mask[g] &&
                (cnt_flat[g*CW +: CW] < thresh[g]);
        end
    endgenerate

    // wakeup decision over the two groups
    always @* begin
        if (both_groups)
            next_wake = |(next_touched & first_group_mask) &&
                        |(next_touched & second_group_mask);
        else
            next_wake = |(next_touched & first_group_mask);
    end

    // scan sequencer; runs without any cpu help so it works in sleep
    always @(posedge clk_sys) begin
        if (srst) begin
            state <= S_IDLE;
            st_cnt <= 16'h0000;
            tmr <= 16'h0000;
            cnt_clr <= 1'b0;
            cnt_en <= 1'b0;
            touch_bias_powerup <= 1'b0;
            pad_powerup <= {NPAD{1'b0}};
            pad_start <= {NPAD{1'b0}};
            touched <= {NPAD{1'b0}};
        end else begin
            cnt_clr <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_req) begin
                        state <= S_BIAS;
                        st_cnt <= 16'h0000;
                        tmr <= 16'h0000;
                        cnt_clr <= 1'b1;
                        touch_bias_powerup <= 1'b1;
                    end else if (!start_source_select) begin
                        tmr <= tmr + 16'h0001;
                    end
                end
                S_BIAS: begin
                    if (st_cnt >= {8'h00, dly_bias}) begin
                        state <= S_PWR;
                        st_cnt <= 16'h0000;
                        pad_powerup <= pad_enable_mask;
                    end else begin
                        st_cnt <= st_cnt + 16'h0001;
                    end
                end
                S_PWR: begin
                    if (st_cnt >= {8'h00, dly_pwr}) begin
                        state <= S_MEAS;
                        st_cnt <= 16'h0000;
                        pad_start <= pad_enable_mask;
                        cnt_en <= 1'b1;
                    end else begin
                        st_cnt <= st_cnt + 16'h0001;
                    end
                end
                S_MEAS: begin
                    if (st_cnt >= window) begin
                        state <= S_DONE;
                        cnt_en <= 1'b0;
                        pad_start <= {NPAD{1'b0}};
                        pad_powerup <= {NPAD{1'b0}};
                        touch_bias_powerup <= 1'b0;
                    end else begin
                        st_cnt <= st_cnt + 16'h0001;
                    end
                end
                S_DONE: begin
                    // counts are final here: the window closed last cycle
                    touched <= next_touched;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // software trigger latch; a trigger during a scan is held for the next
    always @(posedge clk_sys) begin
        if (srst)
            sw_pending <= 1'b0;
        else if (trig_wr && start_source_select)
            sw_pending <= 1'b1;
        else if (state == S_IDLE && start_source_select)
            sw_pending <= 1'b0;
        else if (!start_source_select)
            sw_pending <= 1'b0;
    end

    // configuration registers
    always @(posedge clk_sys) begin : cfg
        integer i;
        reg [31:0] m;
        m = 32'h00000000;
        if (srst) begin
            start_source_select <= 1'b0;
            initial_level_select <= 1'b0;
            both_groups <= 1'b0;
            measurement_interval_cycles <= `CTSF_RST_INTERVAL;
            dly_bias <= `CTSF_RST_DLY_BIAS;
            dly_pwr <= `CTSF_RST_DLY_PWR;
            window <= `CTSF_RST_WINDOW;
            pad_enable_mask <= {NPAD{1'b0}};
            first_group_mask <= {NPAD{1'b0}};
            second_group_mask <= {NPAD{1'b0}};
            int_mask <= 2'b00;
            for (i = 0; i < NPAD; i = i + 1)
                thresh[i] <= `CTSF_RST_THRESH;
        end else if (wr) begin
            case (wb_adr_i)
                `CTSF_ADR_CTRL: begin
                    m = merge(ctrl_cur, wb_dat_i, wb_sel_i);
                    start_source_select <= m[`CTSF_CTRL_SRC];
                    initial_level_select <= m[`CTSF_CTRL_LEVEL];
                    both_groups <= m[`CTSF_CTRL_BOTH];
                end
                `CTSF_ADR_INTERVAL: begin
                    m = merge({16'h0000, measurement_interval_cycles},
                              wb_dat_i, wb_sel_i);
                    measurement_interval_cycles <= m[15:0];
                end
                `CTSF_ADR_TIMING: begin
                    m = merge({window, dly_pwr, dly_bias}, wb_dat_i,
                              wb_sel_i);
                    dly_bias <= m[7:0];
                    dly_pwr <= m[15:8];
                    window <= m[31:16];
                end
                `CTSF_ADR_PADEN: begin
                    m = merge({{(32-NPAD){1'b0}}, pad_enable_mask},
                              wb_dat_i, wb_sel_i);
                    pad_enable_mask <= m[NPAD-1:0];
                end
                `CTSF_ADR_GRP1: begin
                    m = merge({{(32-NPAD){1'b0}}, first_group_mask},
                              wb_dat_i, wb_sel_i);
                    first_group_mask <= m[NPAD-1:0];
                end
                `CTSF_ADR_GRP2: begin
                    m = merge({{(32-NPAD){1'b0}}, second_group_mask},
                              wb_dat_i, wb_sel_i);
                    second_group_mask <= m[NPAD-1:0];
                end
                `CTSF_ADR_INTMASK: begin
                    m = merge({30'h0, int_mask}, wb_dat_i, wb_sel_i);
                    int_mask <= m[1:0];
                end
                default: begin
                    if (wb_adr_i[7:6] == `CTSF_ADR_THRESH_HI && idx_ok) begin
                        m = merge({{(32-CW){1'b0}}, thresh[idx]},
                                  wb_dat_i, wb_sel_i);
                        thresh[idx] <= m[CW-1:0];
                    end
                end
            endcase
        end
    end

    // sticky events; a new event wins over a same-cycle clear
    always @(posedge clk_sys) begin : ints
        reg [1:0] clr;
        reg [1:0] set;
        clr = 2'b00;
        set = 2'b00;
        if (wr && wb_adr_i == `CTSF_ADR_INTSTAT && wb_sel_i[0])
            clr = wb_dat_i[1:0];
        if (state == S_DONE) begin
            set[`CTSF_INT_DONE] = 1'b1;
            set[`CTSF_INT_WAKE] = next_wake;
        end
        if (srst) begin
            int_stat <= 2'b00;
            irq <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~clr) | set;
            irq <= |(((int_stat & ~clr) | set) & int_mask);
        end
    end

    // read multiplexer; unmapped addresses read as zero
    always @* begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            `CTSF_ADR_CTRL: rd_data = ctrl_cur;
            `CTSF_ADR_INTERVAL: rd_data = {16'h0000,
                                           measurement_interval_cycles};
            `CTSF_ADR_TIMING: rd_data = {window, dly_pwr, dly_bias};
            `CTSF_ADR_PADEN: rd_data[NPAD-1:0] = pad_enable_mask;
            `CTSF_ADR_GRP1: rd_data[NPAD-1:0] = first_group_mask;
            `CTSF_ADR_GRP2: rd_data[NPAD-1:0] = second_group_mask;
            `CTSF_ADR_STATUS: begin
                rd_data[NPAD-1:0] = touched;
                rd_data[`CTSF_STATUS_BUSY] = busy;
            end
            `CTSF_ADR_INTSTAT: rd_data[1:0] = int_stat;
            `CTSF_ADR_INTMASK: rd_data[1:0] = int_mask;
            default: begin
                if (wb_adr_i[7:6] == `CTSF_ADR_COUNT_HI && idx_ok)
                    rd_data[CW-1:0] = cnt_flat[idx*CW +: CW];
                else if (wb_adr_i[7:6] == `CTSF_ADR_THRESH_HI && idx_ok)
                    rd_data[CW-1:0] = thresh[idx];
            end
        endcase
    end

    // every access, mapped or not, is acked one cycle after it is seen
    always @(posedge clk_sys) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
                wb_dat_o <= rd_data;
        end
    end
endmodule
`default_nettype wire
